/* File: design/adf_frame.sv */
`timescale 1ns/100ps
`include "adf_params.svh"
module adf_frame import adf_pkg::*; #(
	parameter int MAX_BLOCKS = `ADF_MAX_BLOCKS,
	parameter int MAX_READ_BYTES = `ADF_MAX_READ_BYTES
) (
	input wire logic CLOCK,
	input wire logic RESET,
	input wire logic [7:0] STATION_ID,
	input wire logic [7:0] RX_DATA,
	input wire logic RX_VALID,
	output logic RX_READY,
	output logic [7:0] TX_DATA,
	output logic TX_VALID,
	input wire logic TX_READY,
	output logic NAME_VALID,
	output logic [7:0] NAME_CHAR,
	output logic NAME_FIRST,
	output logic MEM_WR,
	output logic [63:0] MEM_WR_DATA,
	output logic [3:0] MEM_WR_SIZE,
	output logic MEM_WR_BIT,
	output logic MEM_RD_REQ,
	output logic [6:0] MEM_RD_IDX,
	input wire logic [7:0] MEM_RD_BYTE
);
	// ==========================================
	// Elaboration checks
	if (MAX_BLOCKS < 1 || MAX_BLOCKS > 16) begin : g_bad_blocks
		$error("MAX_BLOCKS must be 1 to 16");
	end
	if (MAX_READ_BYTES < 1 || MAX_READ_BYTES > 120) begin : g_bad_read
		$error("MAX_READ_BYTES must be 1 to 120");
	end

	// ==========================================
	// Helpers
	// Hex character to nibble, bit 4 flags a valid digit
	function automatic logic [4:0] hexdec(input logic [7:0] c);
		if (c >= 8'h30 && c <= 8'h39) hexdec = {1'b1, c[3:0]};
		else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66))
			hexdec = {1'b1, c[3:0] + 4'h9};
		else hexdec = 5'h00;
	endfunction
	// Nibble to upper-case hex character
	function automatic logic [7:0] hexenc(input logic [3:0] n);
		hexenc = (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
	endfunction
	// Name character: digit, letter or percent
	function automatic logic name_ok(input logic [7:0] c);
		name_ok = (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h5a) ||
			(c >= 8'h61 && c <= 8'h7a) || c == 8'h25;
	endfunction

	// ==========================================
	// State
	adf_regs_t r_reg; // Registered state
	adf_regs_t r_next; // Next state
	logic rx_fire; // Byte taken this cycle
	logic [4:0] h; // Decoded hex of incoming byte
	logic [7:0] acc_n; // Hex byte with incoming nibble
	logic fail; // Parse error this byte
	logic [15:0] fcode; // Its code
	logic [8:0] plen; // Reply payload length in chars
	logic [8:0] pend; // Reply length in chars
	logic [8:0] q; // Char position after type
	logic isdata; // Char is a read data char
	logic [7:0] ch; // Reply char at tx_idx
	logic [10:0] rbytes; // Requested read bytes

	assign rx_fire = RX_VALID && RX_READY;
	assign h = hexdec(RX_DATA);
	assign acc_n = {r_reg.acc[3:0], h[3:0]};
	assign RX_READY = r_reg.st != S_TX && r_reg.st != S_FETCH;
	// Payload: 4 error chars on NAK, block/count/data on read ACK
	assign plen = (r_reg.err != 16'h0000) ? 9'd4 :
		r_reg.rd ? (9'd4 + {1'b0, r_reg.nbytes, 1'b0}) : 9'd0;
	assign pend = r_reg.lower ? (plen + 9'd9) : (plen + 9'd7);
	assign q = {1'b0, r_reg.tx_idx} - 9'd6;
	assign isdata = r_reg.rd && r_reg.err == 16'h0000 && r_reg.tx_idx >= 8'd10 &&
		q < plen;
	assign rbytes = {3'h0, acc_n} * {7'h0, r_reg.size};

	// ==========================================
	// Reply character generator
	always_comb begin
		ch = `ADF_ETX;
		case (r_reg.tx_idx)
			8'd0: ch = (r_reg.err != 16'h0000) ? `ADF_NAK : `ADF_ACK;
			8'd1: ch = hexenc(r_reg.stn[7:4]);
			8'd2: ch = hexenc(r_reg.stn[3:0]);
			8'd3: ch = r_reg.cmd;
			8'd4: ch = r_reg.typ[15:8];
			8'd5: ch = r_reg.typ[7:0];
			default: begin
				if (q < plen && r_reg.err != 16'h0000) begin
					// Error code, four chars high first
					case (q[1:0])
						2'd0: ch = hexenc(r_reg.err[15:12]);
						2'd1: ch = hexenc(r_reg.err[11:8]);
						2'd2: ch = hexenc(r_reg.err[7:4]);
						default: ch = hexenc(r_reg.err[3:0]);
					endcase
				end else if (q < plen) begin
					// One block, byte count, then data
					if (q == 9'd0) ch = 8'h30;
					else if (q == 9'd1) ch = 8'h31;
					else if (q == 9'd2) ch = hexenc({1'b0, r_reg.nbytes[6:4]});
					else if (q == 9'd3) ch = hexenc(r_reg.nbytes[3:0]);
					else if (q[0] == 1'b0) ch = hexenc(r_reg.rd_byte[7:4]);
					else ch = hexenc(r_reg.rd_byte[3:0]);
				end else if (q == plen) ch = `ADF_ETX;
				else if (q == plen + 9'd1) ch = hexenc(r_reg.sum[7:4]);
				else ch = hexenc(r_reg.sum[3:0]);
			end
		endcase
	end

	// ==========================================
	// Next state
	always_comb begin
		r_next = r_reg;
		r_next.wr = 1'b0;
		r_next.name_v = 1'b0;
		fail = 1'b0;
		fcode = 16'h0000;
		if (rx_fire && RX_DATA == `ADF_ENQ) begin
			// Frame start, also restarts a broken frame
			r_next.st = S_STN;
			r_next.sum = RX_DATA;
			r_next.err = 16'h0000;
			r_next.cnt = 5'h00;
			r_next.blk = 5'h00;
			r_next.mine = 1'b0; // Silent until the station matches
		end else if (rx_fire && r_reg.st != S_IDLE) begin
			if (r_reg.st != S_SUM) r_next.sum = r_reg.sum + RX_DATA;
			r_next.acc = acc_n;
			r_next.cnt = r_reg.cnt + 5'h01;
			// Hex fields
			if ((r_reg.st == S_STN || r_reg.st == S_NBLK || r_reg.st == S_LEN ||
				r_reg.st == S_DATA || r_reg.st == S_NUM || r_reg.st == S_SUM) && !h[4]) begin
				fail = 1'b1;
				fcode = `ADF_ERR_HEX;
			end else begin
				case (r_reg.st)
					S_STN: begin
						if (r_reg.cnt[0]) begin
							r_next.stn = acc_n;
							r_next.mine = acc_n == STATION_ID;
							r_next.st = S_CMD;
						end
					end
					S_CMD: begin
						r_next.cmd = RX_DATA;
						r_next.lower = RX_DATA == `ADF_CMD_WL || RX_DATA == `ADF_CMD_RL;
						r_next.rd = RX_DATA == `ADF_CMD_R || RX_DATA == `ADF_CMD_RL;
						r_next.cnt = 5'h00;
						r_next.st = S_TYP;
						if (RX_DATA != `ADF_CMD_W && RX_DATA != `ADF_CMD_WL &&
							RX_DATA != `ADF_CMD_R && RX_DATA != `ADF_CMD_RL) begin
							fail = 1'b1;
							fcode = `ADF_ERR_CMD;
						end
					end
					S_TYP: begin
						r_next.typ = {r_reg.typ[7:0], RX_DATA};
						if (r_reg.cnt[0]) begin
							r_next.cnt = 5'h00;
							r_next.st = r_reg.rd ? S_LEN : S_NBLK;
							if ({r_reg.typ[7:0], RX_DATA} !=
								(r_reg.rd ? `ADF_TYPE_SEQ : `ADF_TYPE_SS)) begin
								fail = 1'b1;
								fcode = `ADF_ERR_CMD;
							end
						end
					end
					S_NBLK: begin
						if (r_reg.cnt[0]) begin
							r_next.cnt = 5'h00;
							r_next.nblk = acc_n[4:0];
							r_next.st = S_LEN;
							if (acc_n == 8'h00 || acc_n > 8'(MAX_BLOCKS)) begin
								fail = 1'b1;
								fcode = `ADF_ERR_BLOCKS;
							end
						end
					end
					S_LEN: begin
						if (r_reg.cnt[0]) begin
							r_next.cnt = 5'h00;
							r_next.len = acc_n[4:0];
							r_next.size = 4'h0;
							r_next.st = S_NAME;
							if (acc_n == 8'h00 || acc_n > {3'h0, `ADF_MAX_NAME}) begin
								fail = 1'b1;
								fcode = `ADF_ERR_NAMELEN;
							end
						end
					end
					S_NAME: begin
						// Stream the name out, type letter is third char
						r_next.name_v = r_reg.mine;
						r_next.name_c = RX_DATA;
						r_next.name_first = r_reg.cnt == 5'h00;
						if (r_reg.cnt == 5'h02) begin
							r_next.isbit = RX_DATA == 8'h58;
							case (RX_DATA)
								8'h58, 8'h42: r_next.size = 4'h1;
								8'h57: r_next.size = 4'h2;
								8'h44: r_next.size = 4'h4;
								8'h4c: r_next.size = 4'h8;
								default: r_next.size = 4'h0;
							endcase
						end
						if (!name_ok(RX_DATA)) begin
							fail = 1'b1;
							fcode = `ADF_ERR_NAME;
						end else if (r_reg.cnt == r_reg.len - 5'h01) begin
							r_next.cnt = 5'h00;
							r_next.val = 64'h0;
							r_next.acc = 8'h00;
							r_next.st = r_reg.rd ? S_NUM : S_DATA;
							if (r_next.size == 4'h0 ||
								(r_reg.blk != 5'h00 && r_next.size != r_reg.psize)) begin
								fail = 1'b1;
								fcode = `ADF_ERR_TYPE;
							end
						end
					end
					S_DATA: begin
						r_next.val = {r_reg.val[59:0], h[3:0]};
						if (r_reg.cnt == {r_reg.size, 1'b0} - 5'h01) begin
							r_next.psize = r_reg.size;
							r_next.blk = r_reg.blk + 5'h01;
							r_next.cnt = 5'h00;
							r_next.st = (r_reg.blk + 5'h01 == r_reg.nblk) ? S_EOT : S_LEN;
							if (r_reg.isbit && r_next.val > 64'h1) begin
								fail = 1'b1;
								fcode = `ADF_ERR_BIT;
							end else begin
								r_next.wr = r_reg.mine && r_reg.err == 16'h0000;
							end
						end
					end
					S_NUM: begin
						if (r_reg.cnt[0]) begin
							r_next.st = S_EOT;
							r_next.nbytes = rbytes[6:0];
							if (r_reg.isbit || acc_n == 8'h00 ||
								({3'h0, acc_n} * {7'h0, r_reg.size}) > 11'(MAX_READ_BYTES)) begin
								fail = 1'b1;
								fcode = `ADF_ERR_COUNT;
							end
						end
					end
					S_EOT: begin
						if (RX_DATA == `ADF_EOT) begin
							r_next.cnt = 5'h00;
							r_next.st = r_reg.lower ? S_SUM : S_TX;
						end else if (r_reg.err == 16'h0000) begin
							r_next.err = `ADF_ERR_FRAME;
						end
					end
					S_SUM: begin
						if (r_reg.cnt[0]) begin
							r_next.st = S_TX;
							if (acc_n != r_reg.sum && r_reg.err == 16'h0000)
								r_next.err = `ADF_ERR_SUM;
						end
					end
					default: r_next.st = S_IDLE;
				endcase
			end
			// First error sticks, rest of frame is skipped to EOT
			if (fail) begin
				if (r_reg.err == 16'h0000) r_next.err = fcode;
				r_next.wr = 1'b0;
				r_next.st = (r_reg.st == S_SUM) ? S_TX : S_EOT;
			end
			// Reply setup; foreign station stays silent
			if (r_next.st == S_TX) begin
				r_next.st = r_reg.mine ? S_TX : S_IDLE;
				r_next.tx_idx = 8'h00;
				r_next.sum = 8'h00;
				r_next.rd_idx = 7'h00;
				r_next.fetched = 1'b0;
			end
		end else if (r_reg.st == S_FETCH) begin
			// Device memory answers in the same cycle
			r_next.rd_byte = MEM_RD_BYTE;
			r_next.fetched = 1'b1;
			r_next.st = S_TX;
		end else if (r_reg.st == S_TX && (!r_reg.tx_valid || TX_READY)) begin
			if ({1'b0, r_reg.tx_idx} == pend) begin
				r_next.tx_valid = 1'b0;
				r_next.st = S_IDLE;
			end else if (isdata && !q[0] && !r_reg.fetched) begin
				r_next.tx_valid = 1'b0;
				r_next.st = S_FETCH;
			end else begin
				r_next.tx_byte = ch;
				r_next.tx_valid = 1'b1;
				r_next.tx_idx = r_reg.tx_idx + 8'h01;
				if (q <= plen || r_reg.tx_idx < 8'd6)
					r_next.sum = r_reg.sum + ch;
				if (isdata && q[0]) begin
					r_next.fetched = 1'b0;
					r_next.rd_idx = r_reg.rd_idx + 7'h01;
				end
			end
		end
	end

	// ==========================================
	// Register
	always_ff @(posedge CLOCK) begin
		if (RESET) r_reg <= '0;
		else r_reg <= r_next;
	end

	// ==========================================
	// Outputs
	assign TX_DATA = r_reg.tx_byte;
	assign TX_VALID = r_reg.tx_valid;
	assign NAME_VALID = r_reg.name_v;
	assign NAME_CHAR = r_reg.name_c;
	assign NAME_FIRST = r_reg.name_first;
	assign MEM_WR = r_reg.wr;
	assign MEM_WR_DATA = r_reg.val;
	assign MEM_WR_SIZE = r_reg.psize;
	assign MEM_WR_BIT = r_reg.isbit;
	assign MEM_RD_REQ = r_reg.st == S_FETCH;
	assign MEM_RD_IDX = r_reg.rd_idx;

	// ==========================================
	// Assertions
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RESET);
	a_nak_header: assert property ($rose(TX_VALID) && r_reg.tx_idx == 8'd1 && r_reg.err != 16'h0 |->
		TX_DATA == `ADF_NAK) else $error("NAK reply without NAK header");
	a_ack_header: assert property ($rose(TX_VALID) && r_reg.tx_idx == 8'd1 && r_reg.err == 16'h0 |->
		TX_DATA == `ADF_ACK) else $error("ACK reply without ACK header");
	a_upper_nosum: assert property (r_reg.st == S_TX && !r_reg.lower |->
		r_reg.tx_idx <= 8'(plen + 9'd7)) else $error("Check value sent for uppercase");
	a_lower_sum: assert property (r_reg.st == S_TX && r_reg.lower |->
		r_reg.tx_idx <= 8'(plen + 9'd9)) else $error("Lowercase reply overran");
	a_bit_value: assert property (MEM_WR && MEM_WR_BIT |-> MEM_WR_DATA <= 64'h1)
		else $error("Bit write above one");
	a_wr_station: assert property (MEM_WR |-> r_reg.mine && r_reg.err == 16'h0)
		else $error("Write for foreign station or failed frame");
	a_wr_blocks: assert property (MEM_WR |-> r_reg.blk >= 5'h1 && r_reg.blk <= r_reg.nblk)
		else $error("Write beyond block count");
	a_read_limit: assert property (MEM_RD_REQ |-> MEM_RD_IDX < 7'(MAX_READ_BYTES) ##1 !MEM_RD_REQ)
		else $error("Read beyond limit");
	a_name_chars: assert property (NAME_VALID |-> name_ok(NAME_CHAR) && r_reg.err == 16'h0 ||
		r_reg.st == S_EOT) else $error("Bad name char passed");
	a_tx_hold: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
		else $error("Reply byte dropped under stall");
endmodule

/* File: include/adf_params.svh */
// Contract
// - Failed request answers NAK, echo, error, ETX.
// - Lowercase NAK reply carries ASCII hex sum.
// - Successful write answers ACK echo ETX, sum if lowercase.
// - Write uses W/w SS; read sequential type.
// - Block count 1 to 16, else rejected.
// - Name length field 1 to 16 characters.
// - Names hold digits, letters and percent only.
// - Data is hex, padded to type width.
// - Hex digits arrive most significant first.
// - Bit data is 00 or 01.
// - Read ACK gives returned byte count hex.
// - Read longer than 120 bytes is rejected.
`ifndef ADF_PARAMS_SVH
`define ADF_PARAMS_SVH
// ==========================================
// Control characters
`define ADF_ENQ 8'h05
`define ADF_EOT 8'h04
`define ADF_ACK 8'h06
`define ADF_NAK 8'h15
`define ADF_ETX 8'h03
// ==========================================
// Command characters
`define ADF_CMD_W 8'h57
`define ADF_CMD_WL 8'h77
`define ADF_CMD_R 8'h52
`define ADF_CMD_RL 8'h72
`define ADF_TYPE_SS 16'h5353
`define ADF_TYPE_SEQ 16'h5342
// ==========================================
// Limits
`define ADF_MAX_BLOCKS 16
`define ADF_MAX_NAME 5'h10
`define ADF_MAX_READ_BYTES 120
// ==========================================
// Error codes, values arbitrary
`define ADF_ERR_HEX 16'h0001
`define ADF_ERR_CMD 16'h0002
`define ADF_ERR_BLOCKS 16'h0003
`define ADF_ERR_NAMELEN 16'h0004
`define ADF_ERR_NAME 16'h0005
`define ADF_ERR_TYPE 16'h0006
`define ADF_ERR_BIT 16'h0007
`define ADF_ERR_COUNT 16'h0008
`define ADF_ERR_FRAME 16'h0009
`define ADF_ERR_SUM 16'h000a
`endif

/* File: include/adf_pkg.sv */
package adf_pkg;
	// Frame handler states
	typedef enum logic [3:0] {
		S_IDLE, S_STN, S_CMD, S_TYP, S_NBLK, S_LEN, S_NAME,
		S_DATA, S_NUM, S_EOT, S_SUM, S_TX, S_FETCH
	} adf_state_t;

	// Whole state of the handler
	typedef struct packed {
		adf_state_t st;
		logic [7:0] stn;
		logic [7:0] cmd;
		logic [15:0] typ;
		logic mine;
		logic lower;
		logic rd;
		logic [15:0] err;
		logic [7:0] acc;
		logic [4:0] cnt;
		logic [4:0] nblk;
		logic [4:0] blk;
		logic [4:0] len;
		logic [3:0] size;
		logic [3:0] psize;
		logic isbit;
		logic [63:0] val;
		logic [7:0] sum;
		logic [7:0] tx_byte;
		logic tx_valid;
		logic [7:0] tx_idx;
		logic [6:0] nbytes;
		logic [6:0] rd_idx;
		logic fetched;
		logic [7:0] rd_byte;
		logic wr;
		logic name_v;
		logic [7:0] name_c;
		logic name_first;
	} adf_regs_t;
endpackage

/* File: testbench/adf_host_model.sv */
`timescale 1ns/100ps
// ==========================================
// Host side model: takes reply bytes, stalls when slow
module adf_host_model (
	input wire logic CLOCK,
	input wire logic [7:0] TX_DATA,
	input wire logic TX_VALID,
	output logic TX_READY,
	input wire logic SLOW
);
	logic [7:0] got[$]; // Reply bytes taken
	logic [1:0] ph = 2'h0; // Stall phase
	initial TX_READY = 1'b1;
	// Take a byte on a ready edge, then choose the next ready level
	always @(posedge CLOCK) begin
		if (TX_VALID === 1'b1 && TX_READY === 1'b1) begin
			got.push_back(TX_DATA);
		end
		ph <= ph + 2'h1;
		TX_READY <= #1 !(SLOW && ph == 2'h0);
	end
endmodule

/* File: testbench/adf_frame_tb.sv */
`timescale 1ns/100ps
`include "adf_params.svh"
module adf_frame_tb import adf_pkg::*;;
	typedef logic [7:0] adf_bq_t[$];
	// ==========================================
	// Signals
	logic CLOCK = 1'b0, RESET = 1'b1, RX_VALID = 1'b0, SLOW = 1'b0;
	logic [7:0] STATION_ID = 8'h0, RX_DATA = 8'h0;
	logic [7:0] MEM_RD_BYTE, TX_DATA, NAME_CHAR;
	logic RX_READY, TX_VALID, TX_READY, NAME_VALID, NAME_FIRST, MEM_WR, MEM_WR_BIT, MEM_RD_REQ;
	logic [63:0] MEM_WR_DATA;
	logic [3:0] MEM_WR_SIZE;
	logic [6:0] MEM_RD_IDX;
	int bad_count = 0, n_checks = 0;
	int n_first = 0, n_rd = 0; // Name starts and memory reads seen
	integer seed;
	logic [68:0] wq[$], ew[$]; // Seen and expected writes
	adf_bq_t nq, nil; // Seen name chars, empty payload
	logic [7:0] tl[5] = '{8'h58, 8'h42, 8'h57, 8'h44, 8'h4c}; // Type letters
	logic [3:0] szs[5] = '{4'h1, 4'h1, 4'h2, 4'h4, 4'h8}; // Type sizes
	// ==========================================
	// Clock, memory and monitors
	initial forever #10 CLOCK = ~CLOCK;
	function automatic logic [7:0] mem_at(input logic [6:0] i);
		return {i, 1'b0} ^ 8'ha5;
	endfunction
	assign MEM_RD_BYTE = mem_at(MEM_RD_IDX);
	// Record writes and name chars
	always @(posedge CLOCK) begin
		if (MEM_WR === 1'b1) wq.push_back({MEM_WR_BIT, MEM_WR_SIZE, MEM_WR_DATA});
		if (NAME_VALID === 1'b1) nq.push_back(NAME_CHAR);
		if (NAME_VALID === 1'b1 && NAME_FIRST === 1'b1) n_first++;
		if (MEM_RD_REQ === 1'b1) n_rd++;
	end
	adf_frame #(.MAX_BLOCKS(16), .MAX_READ_BYTES(120)) adf_frame_i (.CLOCK(CLOCK),
		.RESET(RESET), .STATION_ID(STATION_ID), .RX_DATA(RX_DATA), .RX_VALID(RX_VALID),
		.RX_READY(RX_READY), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
		.NAME_VALID(NAME_VALID), .NAME_CHAR(NAME_CHAR), .NAME_FIRST(NAME_FIRST), .MEM_WR(MEM_WR),
		.MEM_WR_DATA(MEM_WR_DATA), .MEM_WR_SIZE(MEM_WR_SIZE), .MEM_WR_BIT(MEM_WR_BIT),
		.MEM_RD_REQ(MEM_RD_REQ), .MEM_RD_IDX(MEM_RD_IDX), .MEM_RD_BYTE(MEM_RD_BYTE));
	adf_host_model host_i (.CLOCK(CLOCK), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID),
		.TX_READY(TX_READY), .SLOW(SLOW));
	// ==========================================
	// Frame builders
	function automatic logic [7:0] hc(input logic [3:0] n);
		return (n < 4'ha) ? 8'h30 + n : 8'h37 + n;
	endfunction
	// Hex chars, most significant first
	function automatic adf_bq_t hx(input logic [63:0] v, input int n);
		adf_bq_t q;
		for (int i = n - 1; i >= 0; i--) q.push_back(hc(v[4*i +: 4]));
		return q;
	endfunction
	// Header, station, command, type, body, tail, sum when lowercase
	function automatic adf_bq_t frame(input logic [7:0] h, s, c, input logic [15:0] t,
		input adf_bq_t b, input logic [7:0] tail);
		adf_bq_t q;
		logic [7:0] sum;
		q = {h, hx(s, 2), c, t[15:8], t[7:0], b, tail};
		sum = 8'h0;
		foreach (q[i]) sum += q[i];
		if (c[5]) q = {q, hx(sum, 2)};
		return q;
	endfunction
	// ==========================================
	// Compare tasks and verdict
	task automatic summarize;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic cmp_q(input adf_bq_t e, input adf_bq_t g);
		int i;
		n_checks++;
		for (i = 0; i < e.size() && i < g.size() && e[i] === g[i]; i++);
		if (i != e.size() || i != g.size()) begin
			bad_count++;
			$display("MISMATCH %0t exp %h got %h", $time, e[i], g[i]);
		end
	endtask
	task automatic cmp_v(input logic [68:0] e, input logic [68:0] g);
		n_checks++;
		if (e !== g) begin
			bad_count++;
			$display("MISMATCH %0t exp %h got %h", $time, e, g);
		end
	endtask
	// Send request bytes back to back, then collect the reply
	task automatic run(input adf_bq_t rq, input adf_bq_t ex);
		host_i.got.delete();
		foreach (rq[i]) begin
			for (int k = 0; RX_READY !== 1'b1; k++) begin
				if (k > 600) begin
					bad_count++;
					summarize();
				end
				@(posedge CLOCK) #1;
			end
			RX_VALID = 1'b1;
			RX_DATA = rq[i];
			@(posedge CLOCK) #1;
		end
		RX_VALID = 1'b0;
		RX_DATA = ~RX_DATA;
		for (int k = 0; k < 2000 && host_i.got.size() < ex.size(); k++) @(posedge CLOCK);
		repeat (20) @(posedge CLOCK);
		#1;
		if (host_i.got.size() < ex.size()) begin
			bad_count++;
			summarize();
		end
		cmp_q(ex, host_i.got);
	endtask
	// ==========================================
	// Main sequence
	initial begin
		adf_bq_t b, nmq, q;
		logic [63:0] d;
		logic [15:0] e, t;
		logic [7:0] c;
		logic lc;
		int ty, nb;
		seed = 32'ha923;
		STATION_ID = 8'($random(seed));
		repeat (16) @(posedge CLOCK);
		#1 RESET = 1'b0;
		// Writes of every type, block counts up to the top value
		for (int i = 0; i < 10; i++) begin
			lc = (i == 2) ? 1'b0 : 1'($random(seed));
			c = lc ? `ADF_CMD_WL : `ADF_CMD_W;
			ty = i % 5;
			nb = (i == 9) ? 16 : 1 + $unsigned($random(seed)) % 3;
			b = hx(nb, 2);
			ew.delete();
			wq.delete();
			nq.delete();
			n_first = 0;
			nmq.delete();
			for (int j = 0; j < nb; j++) begin
				d = {$random(seed), $random(seed)};
				d = (ty == 0) ? d[0] : d >> (64 - 8 * szs[ty]);
				if (i == 2) d = 64'ha;
				q = {8'h25, 8'h4d, tl[ty], hc(j)};
				b = {b, hx(4, 2), q, hx(d, (ty == 0) ? 2 : 2 * szs[ty])};
				nmq = {nmq, q};
				ew.push_back({ty == 0, szs[ty], d});
			end
			run(frame(`ADF_ENQ, STATION_ID, c, `ADF_TYPE_SS, b, `ADF_EOT),
				frame(`ADF_ACK, STATION_ID, c, `ADF_TYPE_SS, nil, `ADF_ETX));
			cmp_q(nmq, nq);
			cmp_v(ew.size(), wq.size());
			cmp_v(nb, n_first);
			foreach (ew[j]) cmp_v(ew[j], wq[j]);
		end
		SLOW = 1'b1;
		// Foreign station: no reply, no write, no name
		wq.delete();
		n_first = 0;
		run(frame(`ADF_ENQ, STATION_ID ^ 8'h1, `ADF_CMD_W, `ADF_TYPE_SS, b, `ADF_EOT), nil);
		cmp_v(0, wq.size());
		cmp_v(0, n_first);
		// Refused requests, both cases
		for (int k = 0; k < 9; k++) begin
			lc = k[0] | (k == 8);
			c = lc ? `ADF_CMD_WL : `ADF_CMD_W;
			t = `ADF_TYPE_SS;
			b = {hx(1, 2), hx(4, 2), 8'h25, 8'h4d, 8'h57, 8'h30, hx(0, 4)};
			e = `ADF_ERR_SUM;
			case (k)
				0: begin b = hx(0, 2); e = `ADF_ERR_BLOCKS; end
				1: begin b = hx(17, 2); e = `ADF_ERR_BLOCKS; end
				2: begin b = {hx(1, 2), hx(0, 2)}; e = `ADF_ERR_NAMELEN; end
				3: begin b[7] = 8'h23; e = `ADF_ERR_NAME; end
				4: begin b = {b[0:5], 8'h58, 8'h30, hx(2, 2)}; e = `ADF_ERR_BIT; end
				5: begin b = {hx(2, 2), b[2:$], hx(4, 2), 8'h25, 8'h4d, 8'h42, 8'h31, hx(0, 2)};
					e = `ADF_ERR_TYPE; end
				6, 7: begin c = lc ? `ADF_CMD_RL : `ADF_CMD_R;
					t = `ADF_TYPE_SEQ;
					b = {b[2:7], hx(k == 6 ? 61 : 0, 2)};
					e = `ADF_ERR_COUNT; end
				default: ;
			endcase
			q = frame(`ADF_ENQ, STATION_ID, c, t, b, `ADF_EOT);
			if (k == 8) q[$] = (q[$] == 8'h30) ? 8'h31 : 8'h30;
			run(q, frame(`ADF_NAK, STATION_ID, c, t, hx(e, 4), `ADF_ETX));
		end
		// Reads, smallest and largest counts
		for (int n = 1; n <= 60; n += 59) begin
			c = (n == 60) ? `ADF_CMD_RL : `ADF_CMD_R;
			q = {hx(1, 2), hx(2 * n, 2)};
			for (int x = 0; x < 2 * n; x++) q = {q, hx(mem_at(x), 2)};
			n_rd = 0;
			run(frame(`ADF_ENQ, STATION_ID, c, `ADF_TYPE_SEQ,
				{hx(4, 2), 8'h25, 8'h4d, 8'h57, 8'h30, hx(n, 2)}, `ADF_EOT),
				frame(`ADF_ACK, STATION_ID, c, `ADF_TYPE_SEQ, q, `ADF_ETX));
			cmp_v(2 * n, n_rd);
		end
		summarize();
	end
endmodule
